/* File: core/tbp_pkg.sv */
/*
  shared constants for the two-channel 10-bit pulse-width modulator:
  register offsets, field positions, reset values and timing.
  assumes a single 100 MHz system clock and a plain register port.
*/
package tbp_pkg;
  localparam int TBP_ADDR_W = 12;
  localparam int TBP_CH_N = 2;
  localparam logic [11:0] TBP_DUTY_CH6 = 12'h38c;
  localparam logic [11:0] TBP_CTRL_CH6 = 12'h38e;
  localparam logic [11:0] TBP_DUTY_CH7 = 12'h390;
  localparam logic [11:0] TBP_CTRL_CH7 = 12'h392;
  localparam logic [11:0] TBP_PERIOD = 12'h3a0;
  localparam logic [11:0] TBP_TIMER = 12'h3a2;
  localparam logic [11:0] TBP_PINS = 12'h3a4;
  localparam int TBP_EN_BIT = 7;
  localparam int TBP_OUT_BIT = 5;
  localparam int TBP_POL_BIT = 4;
  localparam int TBP_ON_BIT = 7;
  localparam int TBP_FLAG_BIT = 6;
  localparam int TBP_PS_LSB = 0;
  localparam logic [7:0] TBP_CTRL_RST = 8'h00;
  localparam logic [7:0] TBP_PERIOD_RST = 8'hff;
  localparam logic [1:0] TBP_DIR_RST = 2'h3;
  localparam logic [15:0] TBP_DUTY_INIT = 16'h0000;
  localparam int TBP_SYS_DIV = 4;
endpackage : tbp_pkg

/* File: core/tbp_chan.sv */
/*
  one modulator channel: double-buffered duty, compare, polarity.
  assumes the shared time base and period-match strobe from the top.
*/
`timescale 1ns/1ns
module tbp_chan
  import tbp_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // time base
  input wire logic tick_in,
  input wire logic wrap_in,
  input wire logic [9:0] base_in,
  // setup
  input wire logic enable_in,
  input wire logic invert_in,
  input wire logic [15:0] duty_in,
  input wire logic [7:0] period_in,
  // result
  output logic level_out,
  output logic pin_level_out
);
  logic [9:0] duty_buf;
  logic raw;
  logic [9:0] next_duty;

  assign next_duty = {duty_in[15:8], duty_in[7:6]};

  // buffered duty latched at each period wrap only
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      duty_buf <= 10'h000;
    else if (tick_in && wrap_in)
      duty_buf <= next_duty;
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      raw <= 1'b0;
    else if (!enable_in)
      raw <= 1'b0;
    else if (tick_in)
    begin
      if (wrap_in)
        raw <= (next_duty != 10'h000);
      // compare one ahead so the level stays high for exactly duty ticks while duty is below four times the period value
      else if (base_in + 10'h001 == duty_buf && duty_buf < {period_in, 2'h0})
        raw <= 1'b0;
    end
  end

  assign level_out = raw ^ invert_in;
  assign pin_level_out = level_out;
endmodule : tbp_chan

/* File: core/tbp_top.sv */
/*
  two-channel timer-based 10-bit modulator with its 8-bit period timer
  and register port. assumes strobes one cycle long, never together;
  sleep_in is a synchronous level from the same clock domain.
*/
`timescale 1ns/1ns
// Overview of operation
// - reset clears control and timer registers, period goes to ff, pins become inputs
// - output reaches pin only when direction cleared
// - duty is high byte plus bits 7:6
// - duty kept across ordinary resets
// - control bit 7 enables modulator
// - control bit 5 reads output level
// - control bit 4 inverts output
// - set on wrap, clear on duty match
// - duty double-buffered, loaded on period match
// - time base is counter plus two bits
// - sleep freezes counter and output level
module tbp_top
  import tbp_pkg::*;
(
  // clock, reset and sleep
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic sleep_in,
  // register port
  input wire logic [11:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [15:0] rdata_out,
  // port pins and internal routing
  input wire logic [1:0] latch_in,
  output logic [1:0] pin_out,
  output logic [1:0] pin_oe_n_out,
  output logic [1:0] mod_out
);
  logic [15:0] duty [TBP_CH_N];
  logic [7:0] ctrl [TBP_CH_N];
  logic [7:0] period_limit;
  logic [7:0] period_counter;
  logic [7:0] timer_cfg;
  logic timer_overflow_flag;
  logic [1:0] pin_direction_bit;
  logic [1:0] route;
  logic [1:0] sub;
  logic [5:0] pre_cnt;
  logic [5:0] pre_lim;
  logic tick;
  logic wrap;
  logic [1:0] level;
  logic [15:0] next_rdata;
  logic period_wr;
  logic timer_wr;
  logic pins_wr;
  logic run;

  // one decode per register slot keeps the write processes short
  assign period_wr = wr_in && addr_in == TBP_PERIOD;
  assign timer_wr = wr_in && addr_in == TBP_TIMER;
  assign pins_wr = wr_in && addr_in == TBP_PINS;
  assign run = timer_cfg[TBP_ON_BIT] && !sleep_in;

  // duty slots have no reset at all so they survive every reset; until
  // software loads them they read back unknown
  genvar gi;
  generate
    for (gi = 0; gi < TBP_CH_N; gi++)
    begin : g_ch
      logic [11:0] da;
      logic [11:0] ca;
      logic dw;
      logic cw;
      assign da = (gi == 0) ? TBP_DUTY_CH6 : TBP_DUTY_CH7;
      assign ca = (gi == 0) ? TBP_CTRL_CH6 : TBP_CTRL_CH7;
      assign dw = wr_in && addr_in == da;
      assign cw = wr_in && addr_in == ca;
      always_ff @(posedge clk_in)
      begin
        if (dw)
          duty[gi] <= wdata_in;
      end
      always_ff @(posedge clk_in or posedge rst_in)
      begin
        if (rst_in)
          ctrl[gi] <= TBP_CTRL_RST;
        else if (cw)
          ctrl[gi] <= {wdata_in[TBP_EN_BIT], 2'h0, wdata_in[TBP_POL_BIT], 4'h0};
      end
      // the raw level stays inside the channel; only the polarised level leaves
      tbp_chan u_chan (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .tick_in(tick),
        .wrap_in(wrap),
        .base_in({period_counter, sub}),
        .enable_in(ctrl[gi][TBP_EN_BIT]),
        .invert_in(ctrl[gi][TBP_POL_BIT]),
        .duty_in(duty[gi]),
        .period_in(period_limit),
        .level_out(level[gi]),
        .pin_level_out()
      );
      assign mod_out[gi] = level[gi];
      assign pin_out[gi] = route[gi] ? level[gi] : latch_in[gi];
      assign pin_oe_n_out[gi] = pin_direction_bit[gi];
    end
  endgenerate

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      period_limit <= TBP_PERIOD_RST;
    else if (period_wr)
      period_limit <= wdata_in[7:0];
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      timer_cfg <= TBP_CTRL_RST;
    else if (timer_wr)
      timer_cfg <= {wdata_in[TBP_ON_BIT], 5'h00, wdata_in[TBP_PS_LSB +: 2]};
  end

  // pins come up as inputs so nothing drives them before software routes them
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pin_direction_bit <= TBP_DIR_RST;
      route <= 2'h0;
    end
    else if (pins_wr)
    begin
      pin_direction_bit <= wdata_in[1:0];
      route <= wdata_in[9:8];
    end
  end

  // prescale 1,4,16,64 of the system clock; sub bits advance once per prescaled tick
  always_comb
  begin
    case (timer_cfg[1:0])
      2'h0: pre_lim = 6'd0;
      2'h1: pre_lim = 6'd3;
      2'h2: pre_lim = 6'd15;
      default: pre_lim = 6'd63;
    endcase
  end

  assign tick = run && pre_cnt == pre_lim;
  // sub-count and counter both at their top: the next tick ends the period
  assign wrap = (sub == 2'h3) && (period_counter == period_limit);

  // a ratio lowered mid-count waits for the prescaler to roll over once
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      pre_cnt <= 6'd0;
    else if (run)
      pre_cnt <= tick ? 6'd0 : pre_cnt + 6'd1;
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      sub <= 2'h0;
      period_counter <= 8'h00;
    end
    else if (tick)
    begin
      sub <= sub + 2'h1;
      if (sub == 2'h3)
        period_counter <= wrap ? 8'h00 : period_counter + 8'h01;
    end
  end

  // hardware set wins over a software clear in the same cycle
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      timer_overflow_flag <= 1'b0;
    else if (tick && wrap)
      timer_overflow_flag <= 1'b1;
    else if (timer_wr && !wdata_in[TBP_FLAG_BIT])
      timer_overflow_flag <= 1'b0;
  end

  // unmapped addresses read zero
  always_comb
  begin
    next_rdata = 16'h0000;
    case (addr_in)
      TBP_DUTY_CH6: next_rdata = {duty[0][15:6], 6'h00};
      TBP_DUTY_CH7: next_rdata = {duty[1][15:6], 6'h00};
      TBP_CTRL_CH6: next_rdata = {8'h00, ctrl[0][7], 1'b0, level[0], ctrl[0][4], 4'h0};
      TBP_CTRL_CH7: next_rdata = {8'h00, ctrl[1][7], 1'b0, level[1], ctrl[1][4], 4'h0};
      TBP_PERIOD: next_rdata = {8'h00, period_limit};
      TBP_TIMER: next_rdata = {period_counter, timer_cfg[7], timer_overflow_flag, 4'h0, timer_cfg[1:0]};
      TBP_PINS: next_rdata = {6'h00, route, 6'h00, pin_direction_bit};
      default: next_rdata = 16'h0000;
    endcase
  end

  // cycles without a read strobe return zero so no stale word lingers
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      rdata_out <= 16'h0000;
    else if (rd_in)
      rdata_out <= next_rdata;
    else
      rdata_out <= 16'h0000;
  end
endmodule : tbp_top

/* File: sim/tbp_properties.sv */
/* port assertions for the two-channel modulator.
   assumes a bind into tbp_top. */
`timescale 1ns/1ns
module tbp_properties
  import tbp_pkg::*;
(
  // watched ports
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic sleep_in,
  input wire logic [11:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [15:0] rdata_out,
  input wire logic [1:0] pin_oe_n_out,
  input wire logic [1:0] mod_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  property p_rst; $fell(rst_in) |-> pin_oe_n_out == 2'h3; endproperty
  a_rst: assert property (p_rst) else $error("pins not inputs");
  property p_dir; !(wr_in && addr_in == TBP_PINS) |=> $stable(pin_oe_n_out); endproperty
  a_dir: assert property (p_dir) else $error("direction moved");
  property p_dwr; wr_in && addr_in == TBP_PINS |=> pin_oe_n_out == 2'($past(wdata_in)); endproperty
  a_dwr: assert property (p_dwr) else $error("direction write");
  property p_slp; $past(sleep_in) && !$past(wr_in) |-> $stable(mod_out); endproperty
  a_slp: assert property (p_slp) else $error("sleep level");
  property p_lsb; rd_in && addr_in == TBP_DUTY_CH7 |=> rdata_out[5:0] == 6'h00; endproperty
  a_lsb: assert property (p_lsb) else $error("duty low bits");
  property p_out; rd_in && addr_in == TBP_CTRL_CH6 |=> rdata_out[5] == $past(mod_out[0]); endproperty
  a_out: assert property (p_out) else $error("level readback");
  property p_rsv; rd_in && addr_in == TBP_CTRL_CH6 |=> (rdata_out & 16'hff4f) == 16'h0000; endproperty
  a_rsv: assert property (p_rsv) else $error("control spare bits");
  property p_off; wr_in && addr_in == TBP_CTRL_CH6 && wdata_in[7:4] == 4'h0 && !sleep_in
    ##1 !sleep_in |=> !mod_out[0]; endproperty
  a_off: assert property (p_off) else $error("disabled not low");
  property p_inv; wr_in && addr_in == TBP_CTRL_CH7 && wdata_in[7:4] == 4'h1 && !sleep_in
    ##1 !sleep_in |=> mod_out[1]; endproperty
  a_inv: assert property (p_inv) else $error("invert ignored");
  c_slp: cover property (sleep_in [*8]);
  c_pin: cover property (wr_in && addr_in == TBP_PINS);
  c_rise: cover property ($rose(mod_out[1]));
endmodule : tbp_properties

/* File: sim/tbp_sw.sv */
/* software model: register port master and setup order.
   assumes the modulator's clock. */
`timescale 1ns/1ns
module tbp_sw
  import tbp_pkg::*;
(
  // clock and register port
  input wire logic clk_in,
  input wire logic [15:0] rdata_in,
  output logic [11:0] addr_out = 12'h000,
  output logic [15:0] wdata_out = 16'h0000,
  output logic wr_out = 1'b0,
  output logic rd_out = 1'b0
);
  task automatic acc(input logic w, input logic [11:0] a, input logic [15:0] d, output logic [15:0] q);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= w;
    rd_out <= !w;
    @(posedge clk_in);
    {wr_out, rd_out} <= 2'h0;
    #1 q = rdata_in;
  endtask : acc
  // pins stay inputs until the overflow flag shows the next period wrap, so no torn first pulse
  task automatic setup(input logic [11:0] o, input int p, input int d, input int ps);
    logic [15:0] q;
    q = 16'h0000;
    acc(1'b1, TBP_PINS, 16'h0003, q);
    acc(1'b1, TBP_CTRL_CH6 + o, 16'h0000, q);
    acc(1'b1, TBP_PERIOD, 16'(p), q);
    acc(1'b1, TBP_DUTY_CH6 + o, 16'(d << 6), q);
    acc(1'b1, TBP_TIMER, 16'(128 + ps), q);
    while (q[TBP_FLAG_BIT] !== 1'b1)
      acc(1'b0, TBP_TIMER, 16'h0000, q);
    acc(1'b1, TBP_PINS, 16'h0300, q);
    acc(1'b1, TBP_CTRL_CH6 + o, 16'h0080, q);
  endtask : setup
  // internal use only: pins stay inputs, control goes in early, no flag wait
  task automatic setup_int(input logic [11:0] o, input int p, input int d, input int ps);
    logic [15:0] q;
    q = 16'h0000;
    acc(1'b1, TBP_PINS, 16'h0003, q);
    acc(1'b1, TBP_CTRL_CH6 + o, 16'h0000, q);
    acc(1'b1, TBP_PERIOD, 16'(p), q);
    acc(1'b1, TBP_DUTY_CH6 + o, 16'(d << 6), q);
    acc(1'b1, TBP_CTRL_CH6 + o, 16'h0080, q);
    acc(1'b1, TBP_TIMER, 16'(128 + ps), q);
  endtask : setup_int
endmodule : tbp_sw

/* File: sim/test_tbp_top.sv */
/* self-checking bench for tbp_top.
   assumes tbp_pkg, tbp_sw and the checker are compiled first. */
`timescale 1ns/1ns
module test_tbp_top
  import tbp_pkg::*;
();
  logic clk_in = 1'b0, rst_in = 1'b1, sleep_in = 1'b0, wr_in, rd_in;
  logic [1:0] latch_in = 2'h2, pin_out, pin_oe_n_out, mod_out;
  logic [11:0] addr_in, o;
  logic [15:0] wdata_in, rdata_out, r;
  int fail_count = 0, n_checks = 0, cyc = 0, hn = 0, tn = 0, hi, tot, d, p, c;
  tbp_top uut (.clk_in(clk_in), .rst_in(rst_in), .sleep_in(sleep_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .latch_in(latch_in), .pin_out(pin_out),
    .pin_oe_n_out(pin_oe_n_out), .mod_out(mod_out));
  tbp_sw sw (.clk_in, .rdata_in(rdata_out), .addr_out(addr_in), .wdata_out(wdata_in), .wr_out(wr_in), .rd_out(rd_in));
  always #5 clk_in = ~clk_in;
  // running high and cycle counts; sampled away from the active edge
  always @(negedge clk_in)
  begin
    hn += mod_out[c];
    tn++;
    cyc++;
    if (cyc == 60000)
    begin
      fail_count++;
      finish_test();
    end
  end
  function automatic int high_time(int t, int pr, int du);
    return t * du / (4 * (pr + 1));
  endfunction : high_time
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic finish_test();
    $display("%0d checks, %0d mismatches", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test
  initial
  begin
    void'($urandom(25));
    repeat (5) @(posedge clk_in);
    chk(pin_oe_n_out, 2'h3);
    rst_in <= 1'b0;
    for (c = 0; c < 2; c++)
    begin
      o = 12'(4 * c);
      sw.acc(1'b0, TBP_CTRL_CH6 + o, 16'h0000, r);
      chk(r, 16'h0000);
      sw.acc(1'b1, TBP_DUTY_CH6 + o, 16'hffff, r);
      sw.acc(1'b0, TBP_DUTY_CH6 + o, 16'h0000, r);
      chk(r, 16'hffc0);
    end
    $display("registers done");
    c = 1;
    p = 2 + $urandom % 4;
    d = 1 + $urandom % (4 * p - 1);
    sw.setup_int(12'h004, p, d, 2 + $urandom % 2);
    @(posedge mod_out[c]);
    {hi, tot} = {hn, tn};
    @(posedge mod_out[c]);
    chk(hn - hi, high_time(tn - tot, p, d));
    chk(pin_oe_n_out, 2'h3);
    latch_in <= 2'($urandom);
    @(posedge clk_in);
    #1 chk(pin_out, latch_in);
    $display("internal done");
    for (int k = 0; k < 6; k++)
    begin
      c = k % 2;
      p = 2 + $urandom % 19;
      d = k == 0 ? 1 : k == 1 ? 4 * p - 1 : 1 + $urandom % (4 * p - 1);
      sw.setup(12'(4 * c), p, d, $urandom % 2);
      @(posedge mod_out[c]);
      {hi, tot} = {hn, tn};
      @(posedge mod_out[c]);
      chk(hn - hi, high_time(tn - tot, p, d));
      #1 chk(pin_out[c], mod_out[c]);
      chk(pin_oe_n_out[c], 1'b0);
    end
    $display("waveforms done");
    for (c = 0; c < 2; c++)
    begin
      sw.acc(1'b1, TBP_CTRL_CH6 + 12'(4 * c), 16'h0010, r);
      repeat (3) @(posedge clk_in);
      chk(mod_out[c], 1'b1);
    end
    sw.acc(1'b1, TBP_CTRL_CH6, 16'h0080, r);
    repeat (9) @(posedge clk_in);
    sleep_in <= 1'b1;
    @(posedge clk_in);
    #1 r = 16'(mod_out);
    repeat (400) @(posedge clk_in);
    chk(mod_out, r);
    sleep_in <= 1'b0;
    rst_in <= 1'b1;
    @(posedge clk_in);
    rst_in <= 1'b0;
    sw.acc(1'b0, TBP_DUTY_CH7, 16'h0000, r);
    chk(r, 16'(d << 6));
    chk(pin_oe_n_out, 2'h3);
    sw.acc(1'b0, TBP_CTRL_CH7, 16'h0000, r);
    chk(r, 16'h0000);
    $display("controls done");
    finish_test();
  end
endmodule : test_tbp_top
bind tbp_top tbp_properties u_chk (.clk_in(clk_in), .rst_in(rst_in), .sleep_in(sleep_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .pin_oe_n_out(pin_oe_n_out),
  .mod_out(mod_out));
